// File: inc/hpr_pkg.sv
// constants, codes and state encoding for the home position return sequencer
package hpr_pkg;

    // widths
    localparam int POS_W  = 32;
    localparam int TYPE_W = 4;
    localparam int PT_W   = 8;
    localparam int REV_W  = 16;

    // encoder pulses per motor revolution, one z-phase per wrap
    localparam logic [REV_W-1:0] PULSES_PER_REV = 16'h1000;

    // homing method codes of homing_type_setting
    localparam logic [TYPE_W-1:0] HT_DOG       = 4'h0;
    localparam logic [TYPE_W-1:0] HT_COUNT     = 4'h1;
    localparam logic [TYPE_W-1:0] HT_DATASET   = 4'h2;
    localparam logic [TYPE_W-1:0] HT_STOPPER   = 4'h3;
    localparam logic [TYPE_W-1:0] HT_SERVO_ON  = 4'h4;
    localparam logic [TYPE_W-1:0] HT_REAR_END  = 4'h5;
    localparam logic [TYPE_W-1:0] HT_CNT_FRONT = 4'h6;
    localparam logic [TYPE_W-1:0] HT_CRADLE    = 4'h7;
    localparam logic [TYPE_W-1:0] HT_FIRST_Z   = 4'h8;
    localparam logic [TYPE_W-1:0] HT_DOG_FRONT = 4'h9;
    localparam logic [TYPE_W-1:0] HT_DOGLESS_Z = 4'hA;

    // direction and polarity encodings
    localparam logic DIR_INC        = 1'b0;
    localparam logic DIR_DEC        = 1'b1;
    localparam logic POL_DETECT_OFF = 1'b0;

    // reset values and home address
    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
    localparam logic [POS_W-1:0] HOME_ADDR = 32'h0000_0000;
    localparam logic [REV_W-1:0] REV_RESET = 16'h0000;

    // sequencer states, one-hot
    typedef enum logic [10:0] {
        S_IDLE  = 11'h001,
        S_BACK  = 11'h002,
        S_SEEK  = 11'h004,
        S_ONDOG = 11'h008,
        S_DIST  = 11'h010,
        S_ZWAIT = 11'h020,
        S_REV   = 11'h040,
        S_SHIFT = 11'h080,
        S_PRESS = 11'h100,
        S_DONE  = 11'h200,
        S_SPARE = 11'h400
    } hpr_state_type;

endpackage : hpr_pkg

// File: core/hpr_zgen.sv
// once-per-revolution z-phase derived from encoder steps
`timescale 1ns/10ps
module hpr_zgen
    import hpr_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // encoder step with direction
    input  wire logic enc_step,
    input  wire logic enc_dir,
    // one-cycle pulse each time the index angle is crossed
    output logic      z_pulse_r
);

    logic [REV_W-1:0] angle_r;

    ////////////////////////////////////////////////////////////////////////////
    // angle within one revolution; index lies between last count and zero
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            angle_r   <= REV_RESET;
            z_pulse_r <= 1'b0;
        end else begin
            z_pulse_r <= 1'b0;
            if (enc_step) begin
                if (enc_dir == DIR_INC) begin
                    if (angle_r == PULSES_PER_REV - 16'h0001) begin
                        angle_r   <= REV_RESET;
                        z_pulse_r <= 1'b1;
                    end else begin
                        angle_r <= angle_r + 16'h0001;
                    end
                end else begin
                    if (angle_r == REV_RESET) begin
                        angle_r   <= PULSES_PER_REV - 16'h0001;
                        z_pulse_r <= 1'b1;
                    end else begin
                        angle_r <= angle_r - 16'h0001;
                    end
                end
            end
        end
    end

endmodule : hpr_zgen

// File: core/hpr_home_seq.sv
// home position return sequencer: method selection, dog handling, coordinates
`timescale 1ns/10ps
module hpr_home_seq
    import hpr_pkg::*;
(
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // operating mode from the controller
    input  wire logic             auto_manual_select,
    input  wire logic [PT_W-1:0]  point_table_select_inputs,
    input  wire logic             homing_start,
    input  wire logic             servo_on,
    // settings
    input  wire logic [TYPE_W-1:0] homing_type_setting,
    input  wire logic             homing_direction_setting,
    input  wire logic             input_polarity_setting,
    input  wire logic             abs_system,
    input  wire logic [POS_W-1:0] after_dog_dist,
    input  wire logic [POS_W-1:0] shift_dist,
    // machine side
    input  wire logic             dog_in,
    input  wire logic             enc_step,
    input  wire logic             enc_dir,
    input  wire logic             stopper_hit,
    // retained position of the absolute system
    input  wire logic             abs_backup_valid,
    input  wire logic [POS_W-1:0] abs_backup_pos,
    // motion command and status
    output logic                  motion_run_r,
    output logic                  motion_dir_r,
    output logic                  motion_creep_r,
    output logic                  homing_busy_r,
    output logic                  homing_error_r,
    output logic                  home_done_r,
    output logic                  home_established_r,
    output logic [POS_W-1:0]      position_r
);

    hpr_state_type    state_r;
    hpr_state_type    state_nxt;
    logic             dog_det;
    logic             dog_det_d_r;
    logic             dog_front;
    logic             dog_rear;
    logic             servo_d_r;
    logic             servo_rise;
    logic             start_ok;
    logic             type_ok;
    logic             dist_hit;
    logic             init_r;
    logic             z_pulse;
    logic [POS_W-1:0] dist_r;
    logic [POS_W-1:0] tgt_r;
    logic [POS_W-1:0] tgt_nxt;
    logic             moving;
    logic             rev_move;

    ////////////////////////////////////////////////////////////////////////////
    // z-phase generator
    hpr_zgen u_zgen (
        .clk_sys   (clk_sys),
        .sys_rst   (sys_rst),
        .enc_step  (enc_step),
        .enc_dir   (enc_dir),
        .z_pulse_r (z_pulse)
    );

    ////////////////////////////////////////////////////////////////////////////
    // dog detection with programmable polarity and edge detect
    assign dog_det   = (input_polarity_setting == POL_DETECT_OFF) ? ~dog_in : dog_in;
    assign dog_front = dog_det & ~dog_det_d_r;
    assign dog_rear  = ~dog_det & dog_det_d_r;
    assign servo_rise = servo_on & ~servo_d_r;

    // manual homing only with point tables released
    assign start_ok = homing_start & auto_manual_select
                      & (point_table_select_inputs == '0);
    assign type_ok  = (homing_type_setting <= HT_DOGLESS_Z);
    assign dist_hit = (dist_r >= tgt_r);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            dog_det_d_r <= 1'b0;
            servo_d_r   <= 1'b0;
        end else begin
            dog_det_d_r <= dog_det;
            servo_d_r   <= servo_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state; leaving manual mode drops any run in progress
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (homing_type_setting == HT_SERVO_ON && servo_rise) begin
                    state_nxt = S_DONE;
                end else if (start_ok && type_ok) begin
                    case (homing_type_setting)
                        HT_DATASET:   state_nxt = S_DONE;
                        HT_SERVO_ON:  state_nxt = S_IDLE;
                        HT_STOPPER:   state_nxt = S_PRESS;
                        HT_DOGLESS_Z: state_nxt = S_ZWAIT;
                        default:      state_nxt = dog_det ? S_BACK : S_SEEK;
                    endcase
                end
            end
            S_BACK: begin
                if (!dog_det) begin
                    state_nxt = S_SEEK;
                end
            end
            S_SEEK: begin
                if (dog_front) begin
                    case (homing_type_setting)
                        HT_DOG, HT_REAR_END:                    state_nxt = S_ONDOG;
                        HT_COUNT, HT_CNT_FRONT, HT_DOG_FRONT:   state_nxt = S_DIST;
                        HT_CRADLE:                              state_nxt = S_ZWAIT;
                        HT_FIRST_Z:                             state_nxt = S_REV;
                        default:                                state_nxt = S_IDLE;
                    endcase
                end
            end
            S_ONDOG: begin
                if (dog_rear) begin
                    state_nxt = (homing_type_setting == HT_REAR_END) ? S_DIST : S_ZWAIT;
                end
            end
            S_DIST: begin
                if (dist_hit) begin
                    state_nxt = (homing_type_setting == HT_COUNT) ? S_ZWAIT : S_DONE;
                end
            end
            S_ZWAIT: begin
                if (z_pulse) begin
                    state_nxt = (homing_type_setting == HT_CRADLE) ? S_DONE : S_SHIFT;
                end
            end
            S_REV: begin
                if (z_pulse) begin
                    state_nxt = S_SHIFT;
                end
            end
            S_SHIFT: begin
                if (dist_hit) begin
                    state_nxt = S_DONE;
                end
            end
            S_PRESS: begin
                if (stopper_hit) begin
                    state_nxt = S_DONE;
                end
            end
            S_DONE:  state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
        if (!auto_manual_select && state_r != S_IDLE) begin
            state_nxt = S_IDLE;
        end
    end

    // distance target loaded as each counted leg begins
    always_comb begin
        tgt_nxt = tgt_r;
        if (state_nxt == S_DIST && state_r != S_DIST) begin
            if (homing_type_setting == HT_COUNT) begin
                tgt_nxt = after_dog_dist;
            end else begin
                tgt_nxt = after_dog_dist + shift_dist;
            end
        end else if (state_nxt == S_SHIFT && state_r != S_SHIFT) begin
            tgt_nxt = shift_dist;
        end
    end

    // motion decode of the coming state keeps outputs aligned with state_r
    assign moving   = (state_nxt != S_IDLE) && (state_nxt != S_DONE);
    assign rev_move = (state_nxt == S_BACK) || (state_nxt == S_REV);

    ////////////////////////////////////////////////////////////////////////////
    // state register and motion command
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_r        <= S_IDLE;
            motion_run_r   <= 1'b0;
            motion_dir_r   <= DIR_INC;
            motion_creep_r <= 1'b0;
            homing_busy_r  <= 1'b0;
        end else begin
            state_r        <= state_nxt;
            motion_run_r   <= moving;
            // reverse legs run against the chosen homing direction
            motion_dir_r   <= homing_direction_setting ^ rev_move;
            // fast only until the dog is found or while backing off
            motion_creep_r <= moving && state_nxt != S_SEEK && state_nxt != S_BACK;
            homing_busy_r  <= moving;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // travelled distance, cleared at the start of each leg
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            dist_r <= POS_RESET;
            tgt_r  <= POS_RESET;
        end else begin
            tgt_r <= tgt_nxt;
            if (state_nxt != state_r) begin
                dist_r <= POS_RESET;
            end else if (enc_step) begin
                dist_r <= dist_r + 32'h0000_0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // completion pulse and bad method code
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            home_done_r    <= 1'b0;
            homing_error_r <= 1'b0;
        end else begin
            home_done_r <= (state_nxt == S_DONE);
            if (state_r == S_IDLE && start_ok) begin
                homing_error_r <= !type_ok;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // coordinates; power-up restore is caught one edge after reset release
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            init_r             <= 1'b1;
            position_r         <= POS_RESET;
            home_established_r <= 1'b0;
        end else begin
            init_r <= 1'b0;
            if (init_r) begin
                if (abs_system && abs_backup_valid) begin
                    position_r         <= abs_backup_pos;
                    home_established_r <= 1'b1;
                end
            end else if (state_r == S_DONE) begin
                position_r         <= HOME_ADDR;
                home_established_r <= 1'b1;
            end else begin
                if (enc_step) begin
                    position_r <= (enc_dir == DIR_INC) ? position_r + 32'h0000_0001
                                                       : position_r - 32'h0000_0001;
                end
                // a new run invalidates the old reference until it completes
                if (state_r == S_IDLE && state_nxt != S_IDLE && state_nxt != S_DONE) begin
                    home_established_r <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_flag_on_done: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_r == S_DONE |=> home_established_r && position_r == HOME_ADDR)
        else $error("home not established after completion");

    a_backoff_dir: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_r == S_BACK |-> motion_run_r && motion_dir_r != homing_direction_setting)
        else $error("back-off not against homing direction");

    a_seek_dir: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_r == S_SEEK |-> motion_dir_r == homing_direction_setting && !motion_creep_r)
        else $error("seek direction or speed wrong");

    a_dataset_now: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_r == S_IDLE && start_ok && auto_manual_select
        && homing_type_setting == HT_DATASET |=> state_r == S_DONE ##1 home_established_r)
        else $error("data set homing did not complete at once");

    a_servo_home: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_r == S_IDLE && homing_type_setting == HT_SERVO_ON
        && servo_on && !$past(servo_on) |=> home_done_r)
        else $error("servo-on did not define home");

    a_dog_decel: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_r == S_SEEK && dog_front && auto_manual_select
        && homing_type_setting == HT_DOG |=> state_r == S_ONDOG && motion_creep_r)
        else $error("no deceleration at dog front edge");

    a_cradle_z: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_r == S_ZWAIT && z_pulse && auto_manual_select
        && homing_type_setting == HT_CRADLE |=> home_done_r ##1 state_r == S_IDLE)
        else $error("cradle homing missed z-phase");

    a_rev_dir: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_r == S_REV |-> motion_dir_r != homing_direction_setting)
        else $error("first-z leg not reversed");

    a_stopper_rest: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_r == S_PRESS && stopper_hit && auto_manual_select |=> state_r == S_DONE)
        else $error("stopper contact not taken as home");

    a_mode_abort: assert property (@(posedge clk_sys) disable iff (sys_rst)
        state_r != S_IDLE && !auto_manual_select |=> state_r == S_IDLE && !motion_run_r)
        else $error("run continued outside manual homing mode");

endmodule : hpr_home_seq

// File: bench/hpr_machine_model.sv
// machine model: axis position, proximity dog, stopper and encoder steps
`timescale 1ns/10ps
module hpr_machine_model #(
    parameter int FAST_DIV  = 1,
    parameter int CREEP_DIV = 2
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               sys_rst,
    // motion command from the sequencer
    input  wire logic               motion_run,
    input  wire logic               motion_dir,
    input  wire logic               motion_creep,
    // machine layout chosen by the bench
    input  wire logic               dog_pol,
    input  wire logic signed [31:0] dog_lo,
    input  wire logic signed [31:0] dog_hi,
    input  wire logic signed [31:0] stop_at,
    // sensors back to the sequencer and true axis position to the bench
    output logic                    enc_step,
    output logic                    enc_dir,
    output logic                    dog_in,
    output logic                    stopper_hit,
    output logic signed [31:0]      mpos
);
    int   div_r;
    logic dog_on;
    logic blocked;

    ////////////////////////////////////////////////////////////////////////////
    // dog and stopper levels from the true axis position
    assign dog_on      = (mpos >= dog_lo) && (mpos <= dog_hi);
    assign dog_in      = dog_pol ? dog_on : ~dog_on;
    assign stopper_hit = mpos >= stop_at;
    // the stopper is solid: no step past it in the increasing direction
    assign blocked     = (motion_dir == 1'b0) && (mpos >= stop_at);

    ////////////////////////////////////////////////////////////////////////////
    // step generator; creep is slower so latency errors stay small
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            div_r    <= 0;
            mpos     <= 32'sh0;
            enc_step <= 1'b0;
            enc_dir  <= 1'b0;
        end else begin
            enc_step <= 1'b0;
            enc_dir  <= ~enc_dir; // direction means nothing without a step
            if (!motion_run) begin
                div_r <= 0;
            end else if (div_r >= (motion_creep ? CREEP_DIV : FAST_DIV) - 1) begin
                div_r <= 0;
                if (!blocked) begin
                    enc_step <= 1'b1;
                    enc_dir  <= motion_dir;
                    mpos     <= motion_dir ? mpos - 32'sh1 : mpos + 32'sh1;
                end
            end else begin
                div_r <= div_r + 1;
            end
        end
    end
endmodule : hpr_machine_model

// File: bench/testbench.sv
// self-checking bench: every homing method run against the machine model
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module testbench;
    import hpr_pkg::*;
    localparam int TOL  = 4;
    localparam int CEIL = 90000;

    // clock, reset and controller inputs
    logic                clk_sys = 1'b0;
    logic                sys_rst = 1'b1;
    logic                auto_manual_select = 1'b1;
    logic [PT_W-1:0]     point_table_select_inputs = 8'h00;
    logic                homing_start = 1'b0;
    logic                servo_on = 1'b0;
    logic [TYPE_W-1:0]   homing_type_setting = HT_DOG;
    logic                homing_direction_setting = DIR_INC;
    logic                input_polarity_setting = 1'b1;
    logic                abs_system = 1'b0;
    logic [POS_W-1:0]    after_dog_dist = 32'h0;
    logic [POS_W-1:0]    shift_dist = 32'h0;
    logic                abs_backup_valid = 1'b0;
    logic [POS_W-1:0]    abs_backup_pos = 32'h0;
    // machine layout
    logic signed [31:0]  dog_lo = 32'sd100;
    logic signed [31:0]  dog_hi = 32'sd300;
    logic signed [31:0]  stop_at = 32'sh7FFF_FFFF;
    // machine side and outputs
    logic                dog_in, enc_step, enc_dir, stopper_hit;
    logic signed [31:0]  mpos;
    logic                motion_run_r, motion_dir_r, motion_creep_r, homing_busy_r;
    logic                homing_error_r, home_done_r, home_established_r;
    logic [POS_W-1:0]    position_r;
    int                  num_errors = 0;
    int                  checked = 0;
    int                  cycles = 0;

    hpr_home_seq DUT (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .auto_manual_select(auto_manual_select),
        .point_table_select_inputs(point_table_select_inputs), .homing_start(homing_start),
        .servo_on(servo_on), .homing_type_setting(homing_type_setting),
        .homing_direction_setting(homing_direction_setting),
        .input_polarity_setting(input_polarity_setting), .abs_system(abs_system),
        .after_dog_dist(after_dog_dist), .shift_dist(shift_dist), .dog_in(dog_in),
        .enc_step(enc_step), .enc_dir(enc_dir), .stopper_hit(stopper_hit),
        .abs_backup_valid(abs_backup_valid), .abs_backup_pos(abs_backup_pos),
        .motion_run_r(motion_run_r), .motion_dir_r(motion_dir_r),
        .motion_creep_r(motion_creep_r), .homing_busy_r(homing_busy_r),
        .homing_error_r(homing_error_r), .home_done_r(home_done_r),
        .home_established_r(home_established_r), .position_r(position_r));

    hpr_machine_model #(.FAST_DIV(1), .CREEP_DIV(2)) u_machine (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .motion_run(motion_run_r),
        .motion_dir(motion_dir_r), .motion_creep(motion_creep_r),
        .dog_pol(input_polarity_setting), .dog_lo(dog_lo), .dog_hi(dog_hi),
        .stop_at(stop_at), .enc_step(enc_step), .enc_dir(enc_dir), .dog_in(dog_in),
        .stopper_hit(stopper_hit), .mpos(mpos));

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == CEIL) begin
            num_errors++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task give_verdict;
        begin
            if (num_errors == 0 && checked > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask : give_verdict

    // reset held six cycles; first request only at the second edge after release
    task do_reset;
        begin
            @(posedge clk_sys);
            sys_rst <= 1'b1;
            repeat (6) @(posedge clk_sys);
            sys_rst <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask : do_reset

    // manual homing mode with all table selects low is the controller's part
    task pulse_start;
        begin
            @(posedge clk_sys);
            homing_start <= 1'b1;
            @(posedge clk_sys);
            homing_start <= 1'b0;
        end
    endtask : pulse_start

    // one full homing run; home position compared against the true axis
    task run_case(input logic [3:0] ty, input logic dr, input logic pl, input int lo,
                  input int hi, input int aft, input int sh, input int stp, input int expd);
        int                 n;
        logic signed [31:0] seen;
        logic               on_dog;
        begin
            homing_type_setting      <= ty;
            homing_direction_setting <= dr;
            input_polarity_setting   <= pl;
            dog_lo                   <= lo;
            dog_hi                   <= hi;
            after_dog_dist           <= aft;
            shift_dist               <= sh;
            stop_at                  <= stp;
            on_dog = (lo <= 0) && (hi >= 0);
            do_reset();
            `CHK("est_after_reset", 1'b0, home_established_r)
            if (ty == HT_SERVO_ON) begin
                @(posedge clk_sys);
                servo_on <= 1'b1;
            end else begin
                pulse_start();
            end
            if (ty != HT_DATASET && ty != HT_SERVO_ON) begin
                repeat (3) @(posedge clk_sys);
                `CHK("start_dir", on_dog ? ~dr : dr, motion_dir_r)
                // fast until the dog is found; stopper and dogless legs creep
                `CHK("start_creep", (ty == HT_STOPPER) || (ty == HT_DOGLESS_Z), motion_creep_r)
            end
            n = 0;
            while (home_done_r !== 1'b1 && n < 40000) begin
                @(posedge clk_sys);
                n++;
            end
            // a run that never completes counts as a mismatch here
            `CHK("done_in_time", 1'b1, home_done_r)
            seen = mpos;
            if ((seen - expd <= TOL) && (expd - seen <= TOL))
                seen = expd;
            `CHK("home_axis_pos", expd, seen)
            @(posedge clk_sys);
            `CHK("position_home", HOME_ADDR, position_r)
            `CHK("est_after_done", 1'b1, home_established_r)
            servo_on <= 1'b0;
        end
    endtask : run_case

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        run_case(HT_DOG, DIR_INC, 1'b1, 100, 300, 0, 10, 32'sh7FFF_FFFF, 4106);
        run_case(HT_DOG, DIR_DEC, 1'b1, -300, -100, 0, 10, 32'sh7FFF_FFFF, -4107);
        run_case(HT_DOG, DIR_INC, 1'b0, -50, 50, 0, 10, 32'sh7FFF_FFFF, 4106);
        run_case(HT_COUNT, DIR_INC, 1'b1, 100, 300, 5000, 10, 32'sh7FFF_FFFF, 8202);
        run_case(HT_DATASET, DIR_INC, 1'b1, 100, 300, 0, 10, 32'sh7FFF_FFFF, 0);
        run_case(HT_STOPPER, DIR_INC, 1'b1, 9000, 9010, 0, 0, 700, 700);
        run_case(HT_SERVO_ON, DIR_INC, 1'b1, 100, 300, 0, 10, 32'sh7FFF_FFFF, 0);
        run_case(HT_REAR_END, DIR_INC, 1'b1, 100, 300, 200, 10, 32'sh7FFF_FFFF, 511);
        run_case(HT_CNT_FRONT, DIR_INC, 1'b1, 100, 300, 200, 10, 32'sh7FFF_FFFF, 310);
        run_case(HT_CRADLE, DIR_INC, 1'b1, 100, 300, 0, 10, 32'sh7FFF_FFFF, 4096);
        // z found at -1 on the reverse leg; the shift leg runs in the homing direction
        run_case(HT_FIRST_Z, DIR_INC, 1'b1, 100, 300, 0, 10, 32'sh7FFF_FFFF, 9);
        run_case(HT_DOG_FRONT, DIR_INC, 1'b1, 100, 300, 200, 10, 32'sh7FFF_FFFF, 310);
        run_case(HT_DOGLESS_Z, DIR_INC, 1'b1, 9000, 9010, 0, 10, 32'sh2710, 4106);
        // refusals: code out of range, a table select set, then automatic mode
        homing_type_setting <= 4'hB;
        do_reset();
        pulse_start();
        repeat (2) @(posedge clk_sys);
        `CHK("error_flag", 1'b1, homing_error_r)
        `CHK("busy_bad_code", 1'b0, homing_busy_r)
        homing_type_setting       <= HT_DOG;
        point_table_select_inputs <= 8'h01;
        pulse_start();
        repeat (2) @(posedge clk_sys);
        `CHK("busy_table_set", 1'b0, homing_busy_r)
        point_table_select_inputs <= 8'h00;
        auto_manual_select        <= 1'b0;
        pulse_start();
        repeat (2) @(posedge clk_sys);
        `CHK("busy_auto_mode", 1'b0, homing_busy_r)
        // leaving manual mode mid-run stops motion with no completion
        auto_manual_select <= 1'b1;
        pulse_start();
        repeat (20) @(posedge clk_sys);
        `CHK("busy_running", 1'b1, homing_busy_r)
        auto_manual_select <= 1'b0;
        repeat (3) @(posedge clk_sys);
        `CHK("run_aborted", 1'b0, motion_run_r)
        `CHK("est_aborted", 1'b0, home_established_r)
        // absolute system keeps its position over a power cycle
        auto_manual_select <= 1'b1;
        abs_system         <= 1'b1;
        abs_backup_valid   <= 1'b1;
        abs_backup_pos     <= 32'h0000_1234;
        do_reset();
        `CHK("abs_position", 32'h0000_1234, position_r)
        `CHK("abs_est", 1'b1, home_established_r)
        give_verdict();
    end
endmodule : testbench
